// file: hbc_device.sv
`timescale 1ns/10ps
`include "hbc_map.svh"

// Overview of operation
// - awake and enabled: outputs follow polarity inputs
// - disable active: all switches off, flag low
// - disable toggle clears latch and flag
// - undervoltage: hi-z, flag low, self recovery
// - short during blanking or overtemp latches hi-z, flag low
// - regulation trip: hi-z for fixed off time
// - blanking ignores threshold after each activation
// - short during blanking latches hi-z immediately
// - regulation switching period at least 27 us (off plus blanking)
// - controller holds one input, pulses other
// - operational within wake delay after enable
// - operational within power-on delay
// - floating inputs: polarity high, disable active
// - foldback from 160C, latch at 175C
// - enable low: sleep, hi-z, flag released
// - fault flag is active-low open drain
// - regulation acts on low-side current only
module hbc_device #(
    parameter int TWAKE_CYC = `HBC_TWAKE_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // controller pins
    hbc_if.device pins,
    // analog monitor events
    input wire logic low_side_over_reg,
    input wire logic low_side_over_fold,
    input wire logic high_side_short,
    input wire logic low_side_short,
    input wire logic under_voltage,
    input wire logic [`HBC_TEMP_W-1:0] junction_temp,
    // status
    output logic fault_latched
);
    localparam int TOFF = `HBC_TOFF_CYC;
    localparam int TBLANK = `HBC_TBLANK_CYC;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [11:0] s1_r, s2_r;
    logic [11:0] async_in;
    assign async_in = {pins.polarity_in_a, pins.polarity_in_b,
                       pins.disable_active_high, pins.disable_active_low,
                       pins.enable, low_side_over_reg, low_side_over_fold,
                       high_side_short, low_side_short, under_voltage,
                       junction_temp >= `HBC_TEMP_LATCH,
                       junction_temp >= `HBC_TEMP_FOLD};
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // floating defaults: polarity high, disabled, asleep
            s1_r <= 12'hE00;
            s2_r <= 12'hE00;
        end
        else
        begin
            s1_r <= async_in;
            s2_r <= s1_r;
        end
    end
    logic in_a, in_b, dis_hi, dis_lo_n, en, over_reg, over_fold;
    logic hs_short, ls_short, uv, overtemp, fold;
    assign {in_a, in_b, dis_hi, dis_lo_n, en, over_reg, over_fold,
            hs_short, ls_short, uv, overtemp, fold} = s2_r;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    hbc_pkg::hbc_pwr_t pwr_r, pwr_nxt;
    hbc_pkg::hbc_reg_t reg_r, reg_nxt;
    logic [22:0] wcnt_r, wcnt_nxt;
    logic [12:0] tcnt_r, tcnt_nxt;
    logic latch_r, latch_nxt;
    logic dis_r, dis_nxt;
    logic [1:0] in_r, in_nxt;
    logic [1:0] out_a_r, out_a_nxt, out_b_r, out_b_nxt;
    logic fs_r, fs_nxt;
    logic disabled, drive_ok, temp_fold;

    assign disabled = dis_hi || !dis_lo_n;
    // threshold folds back to the lower comparator when hot
    assign temp_fold = fold;

    function automatic logic [1:0] drv(input logic lvl);
        drv = lvl ? 2'(hbc_pkg::HBC_HIGH) : 2'(hbc_pkg::HBC_LOW);
    endfunction

    always_comb
    begin
        pwr_nxt = pwr_r;
        wcnt_nxt = wcnt_r;
        reg_nxt = reg_r;
        tcnt_nxt = tcnt_r;
        latch_nxt = latch_r;
        dis_nxt = disabled;
        in_nxt = {in_a, in_b};
        // power sequencing
        unique case (pwr_r)
            hbc_pkg::HBC_SLEEP:
            begin
                wcnt_nxt = '0;
                if (en)
                    pwr_nxt = hbc_pkg::HBC_WAKE;
            end
            hbc_pkg::HBC_WAKE:
            begin
                wcnt_nxt = wcnt_r + 23'd1;
                if (wcnt_r == 23'(TWAKE_CYC - 1))
                    pwr_nxt = hbc_pkg::HBC_RUN;
            end
            hbc_pkg::HBC_RUN:
            begin
            end
        endcase
        if (!en)
            pwr_nxt = hbc_pkg::HBC_SLEEP;
        drive_ok = (pwr_r == hbc_pkg::HBC_RUN) && !disabled && !uv
                   && !latch_r;
        // fault latch: a disable edge clears it, new fault wins
        if (dis_r != disabled)
            latch_nxt = 1'b0;
        if (drive_ok && overtemp)
            latch_nxt = 1'b1;
        if (drive_ok && reg_r == hbc_pkg::HBC_BLANK
            && (hs_short || ls_short))
            latch_nxt = 1'b1;
        if (pwr_r != hbc_pkg::HBC_RUN)
            latch_nxt = 1'b0;
        // current regulator
        unique case (reg_r)
            hbc_pkg::HBC_BLANK:
            begin
                tcnt_nxt = tcnt_r + 13'd1;
                if (tcnt_r == 13'(TBLANK - 1))
                    reg_nxt = hbc_pkg::HBC_ON;
            end
            hbc_pkg::HBC_ON:
            begin
                tcnt_nxt = '0;
                // only low-side comparators trip regulation
                if (over_reg || (over_fold && junction_fold(overtemp)))
                    reg_nxt = hbc_pkg::HBC_OFF;
                if (in_r != {in_a, in_b})
                    reg_nxt = hbc_pkg::HBC_BLANK;
            end
            hbc_pkg::HBC_OFF:
            begin
                tcnt_nxt = tcnt_r + 13'd1;
                if (tcnt_r == 13'(TOFF - 1))
                begin
                    reg_nxt = hbc_pkg::HBC_BLANK;
                    tcnt_nxt = '0;
                end
            end
        endcase
        if (!drive_ok)
        begin
            reg_nxt = hbc_pkg::HBC_BLANK;
            tcnt_nxt = '0;
        end
        else if (reg_r == hbc_pkg::HBC_ON && in_r != {in_a, in_b})
            tcnt_nxt = '0;
        // outputs
        if (drive_ok && reg_r != hbc_pkg::HBC_OFF)
        begin
            out_a_nxt = drv(in_a);
            out_b_nxt = drv(in_b);
        end
        else
        begin
            out_a_nxt = 2'(hbc_pkg::HBC_HIZ);
            out_b_nxt = 2'(hbc_pkg::HBC_HIZ);
        end
        fs_nxt = !(pwr_r == hbc_pkg::HBC_RUN
                   && (disabled || uv || latch_r));
    end

    // overtemp comparator feeds foldback through its sync stage
    function automatic logic junction_fold(input logic hot);
        junction_fold = hot || temp_fold;
    endfunction

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_r <= hbc_pkg::HBC_SLEEP;
            reg_r <= hbc_pkg::HBC_BLANK;
            wcnt_r <= '0;
            tcnt_r <= '0;
            latch_r <= 1'b0;
            dis_r <= 1'b1;
            in_r <= 2'h3;
            out_a_r <= 2'(hbc_pkg::HBC_HIZ);
            out_b_r <= 2'(hbc_pkg::HBC_HIZ);
            fs_r <= 1'b1;
        end
        else
        begin
            pwr_r <= pwr_nxt;
            reg_r <= reg_nxt;
            wcnt_r <= wcnt_nxt;
            tcnt_r <= tcnt_nxt;
            latch_r <= latch_nxt;
            dis_r <= dis_nxt;
            in_r <= in_nxt;
            out_a_r <= out_a_nxt;
            out_b_r <= out_b_nxt;
            fs_r <= fs_nxt;
        end
    end

    assign pins.bridge_out_a = out_a_r;
    assign pins.bridge_out_b = out_b_r;
    assign pins.fault_flag_n_o = 1'b0;
    assign pins.fault_flag_n_oe_n = fs_r;
    assign fault_latched = latch_r;
endmodule

// file: hbc_map.svh
`ifndef HBC_MAP_SVH
`define HBC_MAP_SVH

// system clock period in ps (250 MHz)
`define HBC_CLK_PS 4000
// constant off time, min and max in ns
`define HBC_TOFF_MIN_NS 15000
`define HBC_TOFF_MAX_NS 26000
// blanking time, min and max in ns
`define HBC_TBLANK_MIN_NS 12000
`define HBC_TBLANK_MAX_NS 21000
// power-on and wake-up delay, max in ns
`define HBC_TWAKE_MAX_NS 5000000
// controller pulse rate in Hz
`define HBC_PWM_HZ 10000
// least cycle counts, rounded up
`define HBC_TOFF_CYC \
    ((`HBC_TOFF_MIN_NS * 1000 + `HBC_CLK_PS - 1) / `HBC_CLK_PS)
`define HBC_TBLANK_CYC \
    ((`HBC_TBLANK_MIN_NS * 1000 + `HBC_CLK_PS - 1) / `HBC_CLK_PS)
// longest wake delay, rounded down
`define HBC_TWAKE_CYC ((`HBC_TWAKE_MAX_NS / 1000) * (1000000 / `HBC_CLK_PS))
// controller pulse period in cycles
`define HBC_PWM_CYC (1000000000 / `HBC_PWM_HZ * 1000 / `HBC_CLK_PS)
// temperature input width
`define HBC_TEMP_W 8
// foldback start and latch codes of the temperature input
`define HBC_TEMP_FOLD 8'hA0
`define HBC_TEMP_LATCH 8'hAF

`endif

// file: hbc_pkg.sv
package hbc_pkg;
    // drive state of one half-bridge
    typedef enum logic [1:0] {HBC_LOW, HBC_HIGH, HBC_HIZ} hbc_drive_t;
    typedef enum {HBC_SLEEP, HBC_WAKE, HBC_RUN} hbc_pwr_t;
    typedef enum {HBC_BLANK, HBC_ON, HBC_OFF} hbc_reg_t;
endpackage

// file: hbc_if.sv
`timescale 1ns/10ps
interface hbc_if;
    logic polarity_in_a;
    logic polarity_in_b;
    logic disable_active_high;
    logic disable_active_low;
    logic enable;
    // open-drain fault flag: oe low means pulled low
    logic fault_flag_n_o;
    logic fault_flag_n_oe_n;
    logic fault_flag_n;
    logic [1:0] bridge_out_a;
    logic [1:0] bridge_out_b;

    // pull-up on the flag
    assign fault_flag_n = fault_flag_n_oe_n ? 1'b1 : fault_flag_n_o;

    modport device (
        input polarity_in_a, polarity_in_b, disable_active_high,
        input disable_active_low, enable,
        output fault_flag_n_o, fault_flag_n_oe_n, bridge_out_a, bridge_out_b
    );
    modport ctrl (
        output polarity_in_a, polarity_in_b, disable_active_high,
        output disable_active_low, enable,
        input fault_flag_n, bridge_out_a, bridge_out_b
    );
endinterface

// file: hbc_ctrl.sv
`timescale 1ns/10ps
`include "hbc_map.svh"

module hbc_ctrl #(
    parameter int TWAKE_CYC = `HBC_TWAKE_CYC,
    parameter int PWM_CYC = `HBC_PWM_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // device pins
    hbc_if.ctrl pins,
    // user side
    input wire logic run,
    input wire logic reverse,
    input wire logic [7:0] duty,
    input wire logic clear_fault,
    output logic ready,
    output logic fault_seen
);
    // ------------------------------------------------------------
    // wake wait, pwm and fault clear
    // ------------------------------------------------------------
    logic [22:0] wcnt_r, wcnt_nxt;
    logic [15:0] pcnt_r, pcnt_nxt;
    logic pulse_r, pulse_nxt, a_r, a_nxt, b_r, b_nxt, dis_r, dis_nxt;
    logic rdy_r, rdy_nxt, f1_r, f2_r, fs_r, fs_nxt;
    logic [15:0] thr;

    assign thr = 16'((32'(duty) * PWM_CYC) >> 8);

    always_comb
    begin
        wcnt_nxt = wcnt_r;
        rdy_nxt = rdy_r;
        // wait out the wake delay before commanding
        if (!run)
        begin
            wcnt_nxt = '0;
            rdy_nxt = 1'b0;
        end
        else if (wcnt_r == 23'(TWAKE_CYC - 1))
            rdy_nxt = 1'b1;
        else
            wcnt_nxt = wcnt_r + 23'd1;
        pcnt_nxt = (pcnt_r == 16'(PWM_CYC - 1)) ? '0 : pcnt_r + 16'd1;
        pulse_nxt = pcnt_r < thr;
        // hold one input high, pulse the other
        a_nxt = reverse ? 1'b1 : !pulse_r;
        b_nxt = reverse ? !pulse_r : 1'b1;
        dis_nxt = !rdy_r || clear_fault;
        fs_nxt = !f2_r;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wcnt_r <= '0;
            pcnt_r <= '0;
            pulse_r <= 1'b0;
            a_r <= 1'b1;
            b_r <= 1'b1;
            dis_r <= 1'b1;
            rdy_r <= 1'b0;
            f1_r <= 1'b1;
            f2_r <= 1'b1;
            fs_r <= 1'b0;
        end
        else
        begin
            wcnt_r <= wcnt_nxt;
            pcnt_r <= pcnt_nxt;
            pulse_r <= pulse_nxt;
            a_r <= a_nxt;
            b_r <= b_nxt;
            dis_r <= dis_nxt;
            rdy_r <= rdy_nxt;
            f1_r <= pins.fault_flag_n;
            f2_r <= f1_r;
            fs_r <= fs_nxt;
        end
    end

    assign pins.enable = run;
    assign pins.polarity_in_a = a_r;
    assign pins.polarity_in_b = b_r;
    assign pins.disable_active_high = dis_r;
    assign pins.disable_active_low = !dis_r;
    assign ready = rdy_r;
    assign fault_seen = fs_r;
endmodule

// file: hbc_chk.sv
`timescale 1ns/10ps
`include "hbc_map.svh"

module hbc_chk #(
    parameter int TWAKE_CYC = `HBC_TWAKE_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // controller side
    input wire logic polarity_in_a,
    input wire logic polarity_in_b,
    input wire logic disable_active_high,
    input wire logic disable_active_low,
    input wire logic enable,
    // device side
    input wire logic fault_flag_n_o,
    input wire logic fault_flag_n_oe_n,
    input wire logic fault_flag_n,
    input wire logic [1:0] bridge_out_a,
    input wire logic [1:0] bridge_out_b
);
    localparam int TOFF_MIN = `HBC_TOFF_CYC;
    localparam int TOFF_MAX = `HBC_TOFF_MAX_NS * 1000 / `HBC_CLK_PS;
    logic [31:0] en_cnt_r, en_cnt_nxt, off_cnt_r, off_cnt_nxt;
    logic awake, hiz, run_ok;

    assign awake = en_cnt_r > TWAKE_CYC + 8;
    assign hiz = bridge_out_a == hbc_pkg::HBC_HIZ
        && bridge_out_b == hbc_pkg::HBC_HIZ;
    assign run_ok = !disable_active_high && disable_active_low;

    // -----------------------------
    // time since enable, off length
    // -----------------------------
    always_comb
    begin
        en_cnt_nxt = !enable ? 32'h0 : en_cnt_r + {31'h0, !awake};
        off_cnt_nxt = (awake && hiz && fault_flag_n) ? off_cnt_r + 1 : 32'h0;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_cnt_r <= 32'h0;
            off_cnt_r <= 32'h0;
        end
        else
        begin
            en_cnt_r <= en_cnt_nxt;
            off_cnt_r <= off_cnt_nxt;
        end
    end

    // -----------------------------
    // assertions
    // -----------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sleep_hiz_a: assert property (!enable [*5] |-> hiz && fault_flag_n)
        else $error("sleep not quiet");
    wake_quiet_a: assert property (
        en_cnt_r != 0 && en_cnt_r < TWAKE_CYC |-> hiz && fault_flag_n)
        else $error("drive during wake");
    follow_pol_a: assert property (
        (awake && run_ok && $stable({polarity_in_a, polarity_in_b})) [*5]
        |-> bridge_out_a != {1'b0, !polarity_in_a}
        && bridge_out_b != {1'b0, !polarity_in_b})
        else $error("output against polarity");
    disable_off_a: assert property (
        (awake && !run_ok) [*5] |-> hiz && !fault_flag_n)
        else $error("disable not obeyed");
    fault_hiz_a: assert property (
        !fault_flag_n_oe_n && $past(!fault_flag_n_oe_n)
        |-> !fault_flag_n_o && hiz)
        else $error("flag set with bridge driven");
    clear_release_a: assert property (
        awake && $rose(run_ok) ##1 (awake && run_ok) [*6] |-> fault_flag_n)
        else $error("toggle did not clear flag");
    pol_hold_a: assert property (polarity_in_a || polarity_in_b)
        else $error("no input held high");
    off_min_a: assert property (
        !hiz && off_cnt_r > 8 |-> off_cnt_r >= TOFF_MIN)
        else $error("off time too short");
    off_max_a: assert property (off_cnt_r <= TOFF_MAX)
        else $error("off time too long");

    cover property (awake && !hiz);
    cover property (off_cnt_r == TOFF_MIN);
    cover property (awake && run_ok && !fault_flag_n);
endmodule

// file: test_hbridge_control_logic.sv
`timescale 1ns/10ps
`include "hbc_map.svh"

`define CHK(g, e, m) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("unexpected at %0t: %s", $time, m); \
        end \
    end

module test_hbridge_control_logic;
    localparam int TWAKE = 20;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic run = 1'b0;
    logic reverse = 1'b0;
    logic clear_fault = 1'b0;
    logic [7:0] duty = 8'hFF;
    logic over_reg = 1'b0;
    logic over_fold = 1'b0;
    logic hs_short = 1'b0;
    logic ls_short = 1'b0;
    logic uv = 1'b0;
    logic [`HBC_TEMP_W-1:0] temp = 8'h00;
    logic ready, fault_seen, fault_latched;
    int mismatches = 0;
    int checks_done = 0;
    int n;

    always #2 sys_clk = ~sys_clk;

    hbc_if hbc_if_i ();
    hbc_device #(.TWAKE_CYC(TWAKE)) hbc_device_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .pins(hbc_if_i.device), .low_side_over_reg(over_reg),
        .low_side_over_fold(over_fold), .high_side_short(hs_short),
        .low_side_short(ls_short), .under_voltage(uv),
        .junction_temp(temp), .fault_latched(fault_latched));
    hbc_ctrl #(.TWAKE_CYC(TWAKE), .PWM_CYC(64)) hbc_ctrl_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .pins(hbc_if_i.ctrl), .run(run),
        .reverse(reverse), .duty(duty), .clear_fault(clear_fault),
        .ready(ready), .fault_seen(fault_seen));
    hbc_chk #(.TWAKE_CYC(TWAKE)) hbc_chk_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .polarity_in_a(hbc_if_i.polarity_in_a),
        .polarity_in_b(hbc_if_i.polarity_in_b),
        .disable_active_high(hbc_if_i.disable_active_high),
        .disable_active_low(hbc_if_i.disable_active_low),
        .enable(hbc_if_i.enable), .fault_flag_n_o(hbc_if_i.fault_flag_n_o),
        .fault_flag_n_oe_n(hbc_if_i.fault_flag_n_oe_n),
        .fault_flag_n(hbc_if_i.fault_flag_n),
        .bridge_out_a(hbc_if_i.bridge_out_a),
        .bridge_out_b(hbc_if_i.bridge_out_b));

    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask

    function automatic logic hiz();
        return hbc_if_i.bridge_out_a === hbc_pkg::HBC_HIZ
            && hbc_if_i.bridge_out_b === hbc_pkg::HBC_HIZ;
    endfunction

    task automatic check_state(input logic z, input logic f, input logic l,
        input string m);
        `CHK(hiz(), z, m)
        `CHK(hbc_if_i.fault_flag_n, f, m)
        `CHK(fault_latched, l, m)
    endtask

    task automatic wait_drive(input int lim);
        n = 0;
        while (hiz() && n < lim)
        begin
            cyc(1);
            n++;
        end
    endtask

    // disable held active, then released
    task automatic clear();
        clear_fault = 1'b1;
        cyc(10);
        `CHK(hbc_if_i.fault_flag_n, 1'b0, "flag while disabled")
        `CHK(hiz(), 1'b1, "bridge while disabled")
        clear_fault = 1'b0;
        cyc(12);
        check_state(1'b0, 1'b1, 1'b0, "fault cleared");
    endtask

    initial
    begin
        #100000;
        mismatches++;
        end_of_test();
    end

    initial
    begin
        cyc(10);
        rst_n = 1'b1;
        check_state(1'b1, 1'b1, 1'b0, "reset state");
        run = 1'b1;
        cyc(8);
        check_state(1'b1, 1'b1, 1'b0, "wake window");
        cyc(60);
        check_state(1'b0, 1'b1, 1'b0, "forward drive");
        `CHK(hbc_if_i.polarity_in_b, 1'b1, "held input")
        `CHK(ready, 1'b1, "ready")
        // high-side short, low-side short, overtemperature
        for (int k = 0; k < 3; k++)
        begin
            reverse = k[0];
            cyc(6);
            wait_drive(200);
            hs_short = k == 0;
            ls_short = k == 1;
            temp = (k == 2) ? `HBC_TEMP_LATCH : 8'h00;
            cyc(6);
            hs_short = 1'b0;
            ls_short = 1'b0;
            temp = 8'h00;
            cyc(4);
            check_state(1'b1, 1'b0, 1'b1, "fault latch");
            `CHK(fault_seen, 1'b1, "fault seen")
            clear();
        end
        // steady inputs so that blanking can run out
        duty = 8'h00;
        uv = 1'b1;
        cyc(8);
        check_state(1'b1, 1'b0, 1'b0, "undervoltage");
        uv = 1'b0;
        cyc(8);
        check_state(1'b0, 1'b1, 1'b0, "uv recovery");
        cyc(3100);
        over_reg = 1'b1;
        cyc(8);
        over_reg = 1'b0;
        check_state(1'b1, 1'b1, 1'b0, "regulation off");
        wait_drive(7000);
        `CHK(n >= 3740 && n <= 6500, 1'b1, "off time")
        over_reg = 1'b1;
        cyc(8);
        `CHK(hiz(), 1'b0, "blanking ignores trip")
        over_reg = 1'b0;
        cyc(3010);
        over_fold = 1'b1;
        cyc(8);
        `CHK(hiz(), 1'b0, "fold ignored when cool")
        temp = `HBC_TEMP_FOLD;
        cyc(8);
        check_state(1'b1, 1'b1, 1'b0, "foldback trip");
        over_fold = 1'b0;
        temp = 8'h00;
        run = 1'b0;
        cyc(6);
        check_state(1'b1, 1'b1, 1'b0, "sleep");
        end_of_test();
    end
endmodule
